// file: logic/async_sram_access_control.sv
`timescale 1ns/10ps
// Overview of operation
// - write starts only with both low
// - data stable around ending strobe edge
// - strobe low covers float plus setup
// - never drive data while device drives
// - address valid before select falls
// - strobe held high through every read
// - both low stores byte at address
module async_sram_access_control (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic reqValid,
    output logic reqReady,
    input asac_pkg::asac_req_type reqData,
    output logic rspValid,
    output logic [asac_pkg::DATA_W-1:0] rspData,
    output asac_pkg::asac_pins_type memPins,
    input wire logic [asac_pkg::DATA_W-1:0] dataLinesIn,
    output logic [asac_pkg::DATA_W-1:0] dataLinesOut,
    output logic dataLinesOe
);
    // sequencer states, one transfer at a time
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_ADDR,
        ST_WLOW,
        ST_WEND,
        ST_RD,
        ST_RECOV
    } asac_state_type;

    asac_state_type state_q, state_d;
    logic [asac_pkg::CNT_W-1:0] cnt_q, cnt_d;
    asac_pkg::asac_pins_type pins_q, pins_d;
    logic [asac_pkg::DATA_W-1:0] dout_q, dout_d;
    logic oe_q, oe_d;
    logic rv_q, rv_d;
    logic [asac_pkg::DATA_W-1:0] rd_q, rd_d;
    asac_pkg::asac_req_type held;
    wire logic accept;
    wire logic cntDone;
    wire logic [asac_pkg::CNT_W-1:0] cntDown;
    wire logic [asac_pkg::CNT_W-1:0] cntWriteLow;
    wire logic [asac_pkg::CNT_W-1:0] cntAccess;
    wire logic [asac_pkg::CNT_W-1:0] cntRecover;

    // cycle count to constant width
    function automatic logic [asac_pkg::CNT_W-1:0] cyc(input int n);
        cyc = asac_pkg::CNT_W'(n - 1);
    endfunction

    // handshake and counter decode
    assign reqReady = (state_q == ST_IDLE);
    assign accept = reqValid && reqReady;
    assign cntDone = (cnt_q == asac_pkg::CNT_ZERO);
    assign cntDown = cntDone ? cnt_q : cnt_q - asac_pkg::CNT_W'(1);

    // counter loads: each phase ends when the count reaches zero
    assign cntWriteLow = cyc(asac_pkg::WRLOW_CYC);
    assign cntAccess = cyc(asac_pkg::ACCESS_CYC);
    assign cntRecover = cyc(asac_pkg::RECOV_CYC);

    asac_req_hold u_hold (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .load(accept),
        .reqIn(reqData),
        .reqOut(held)
    );

    // sequencer
    always_comb
    begin
        state_d = state_q;
        cnt_d = cntDown;
        pins_d = pins_q;
        dout_d = dout_q;
        oe_d = oe_q;
        rv_d = 1'b0;
        rd_d = rd_q;
        unique case (state_q)
            ST_IDLE:
            begin
                // wait for a request
                if (accept)
                begin
                    // address placed while select still high
                    pins_d.addressLines = reqData.addr;
                    pins_d.gateN = 1'b1;
                    pins_d.strobeN = 1'b1;
                    state_d = ST_ADDR;
                end
            end
            ST_ADDR:
            begin
                pins_d.selectN = 1'b0;
                if (held.write)
                begin
                    // both fall together, device samples through overlap
                    pins_d.strobeN = 1'b0;
                    dout_d = held.wdata;
                    oe_d = 1'b1;
                    cnt_d = cntWriteLow;
                    state_d = ST_WLOW;
                end
                else
                begin
                    // read: gate opens together with select
                    pins_d.gateN = 1'b0;
                    cnt_d = cntAccess;
                    state_d = ST_RD;
                end
            end
            ST_WLOW:
            begin
                if (cntDone)
                begin
                    // strobe rises first and ends the write, data held
                    pins_d.strobeN = 1'b1;
                    state_d = ST_WEND;
                end
            end
            ST_WEND:
            begin
                // data released only after the ending edge
                pins_d.selectN = 1'b1;
                oe_d = 1'b0;
                cnt_d = cntRecover;
                state_d = ST_RECOV;
            end
            ST_RD:
            begin
                // sample the byte as the access time runs out
                if (cntDone)
                begin
                    rd_d = dataLinesIn;
                    rv_d = 1'b1;
                    pins_d.selectN = 1'b1;
                    pins_d.gateN = 1'b1;
                    cnt_d = cntRecover;
                    state_d = ST_RECOV;
                end
            end
            ST_RECOV:
            begin
                // wait for device drivers to float before next drive
                if (cntDone)
                    state_d = ST_IDLE;
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    // sequencer state and phase counter
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            cnt_q <= asac_pkg::CNT_ZERO;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // memory control and address pins, idle on reset
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            pins_q <= asac_pkg::PINS_IDLE;
        else
            pins_q <= pins_d;
    end

    // write data and its driver enable
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            dout_q <= '0;
            oe_q <= 1'b0;
        end
        else
        begin
            dout_q <= dout_d;
            oe_q <= oe_d;
        end
    end

    // read response
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rv_q <= 1'b0;
            rd_q <= '0;
        end
        else
        begin
            rv_q <= rv_d;
            rd_q <= rd_d;
        end
    end

    // outputs from flip-flops
    assign memPins = pins_q;
    assign dataLinesOut = dout_q;
    assign dataLinesOe = oe_q;
    assign rspValid = rv_q;
    assign rspData = rd_q;
endmodule

// file: logic/asac_pkg.sv
package asac_pkg;
    // memory geometry
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int MEM_WORDS = 32768;
    // clock period in picoseconds (40 MHz)
    localparam int CLK_PS = 25000;
    // pin timing figures in picoseconds
    localparam int T_PULSE_PS = 20000;     // strobe low time, slowest grade
    localparam int T_FLOAT_PS = 7000;      // strobe_to_float_delay
    localparam int T_SETUP_PS = 12000;     // data_setup_before_write_end
    localparam int T_ACCESS_PS = 35000;    // address or select to data valid
    localparam int T_RECOV_PS = 8000;      // select high to pins floating
    // least times round up to whole cycles, never below one
    localparam int PULSE_CYC = ((T_PULSE_PS + CLK_PS - 1) / CLK_PS) < 1 ? 1 : ((T_PULSE_PS + CLK_PS - 1) / CLK_PS);
    localparam int WRLOW_RAW = (T_FLOAT_PS + T_SETUP_PS + CLK_PS - 1) / CLK_PS;
    localparam int WRLOW_CYC = WRLOW_RAW > PULSE_CYC ? WRLOW_RAW : PULSE_CYC;
    localparam int ACCESS_CYC = ((T_ACCESS_PS + CLK_PS - 1) / CLK_PS) < 1 ? 1 : ((T_ACCESS_PS + CLK_PS - 1) / CLK_PS);
    localparam int RECOV_CYC = ((T_RECOV_PS + CLK_PS - 1) / CLK_PS) < 1 ? 1 : ((T_RECOV_PS + CLK_PS - 1) / CLK_PS);
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    // user request
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asac_req_type;

    // memory pins seen from the controller
    typedef struct packed {
        logic selectN;
        logic strobeN;
        logic gateN;
        logic [ADDR_W-1:0] addressLines;
    } asac_pins_type;

    localparam asac_pins_type PINS_IDLE = '{selectN: 1'b1, strobeN: 1'b1, gateN: 1'b1, addressLines: '0};
endpackage

// file: logic/asac_req_hold.sv
`timescale 1ns/10ps
// one-word holding register for the accepted request
module asac_req_hold (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic load,
    input asac_pkg::asac_req_type reqIn,
    output asac_pkg::asac_req_type reqOut
);
    asac_pkg::asac_req_type req_q;

    // capture on acceptance only
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            req_q <= '0;
        else if (load)
            req_q <= reqIn;
    end

    assign reqOut = req_q;
endmodule

// file: test/asac_monitor.sv
`timescale 1ns/10ps
module asac_monitor (
    input wire logic clk_sys,
    input wire logic nrst,
    input asac_pkg::asac_pins_type memPins,
    input wire logic rspValid,
    input wire logic [asac_pkg::DATA_W-1:0] dataLinesOut,
    input wire logic dataLinesOe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // strobe ends the write, select follows one cycle later
    sequence s_wrEnd;
        memPins.strobeN && !memPins.selectN ##1 memPins.selectN && !dataLinesOe;
    endsequence
    // strobe stays high until read data returns
    sequence s_rdWait;
        memPins.strobeN [*3] ##0 rspValid;
    endsequence
    chk_write_start_selected: assert property ($fell(memPins.strobeN) |-> !memPins.selectN && dataLinesOe)
        else $error("strobe low without select");
    chk_data_at_end: assert property ($rose(memPins.strobeN) |-> dataLinesOe && $stable(dataLinesOut))
        else $error("data moved at write end");
    chk_pulse_length: assert property ($fell(memPins.strobeN) |-> ##1 s_wrEnd)
        else $error("bad write pulse");
    chk_no_contention: assert property (!(dataLinesOe && !memPins.selectN && !memPins.gateN && memPins.strobeN))
        else $error("bus contention");
    chk_addr_before_select: assert property ($fell(memPins.selectN) |-> $stable(memPins.addressLines))
        else $error("address late");
    chk_read_strobe_high: assert property ($fell(memPins.gateN) |-> s_rdWait)
        else $error("strobe low in read");
    chk_drive_in_write: assert property (dataLinesOe |-> !memPins.selectN && memPins.gateN)
        else $error("data driven outside write");
    chk_addr_held: assert property (!memPins.selectN |=> memPins.selectN || $stable(memPins.addressLines))
        else $error("address moved");
endmodule

bind async_sram_access_control asac_monitor MON (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .memPins(memPins),
    .rspValid(rspValid),
    .dataLinesOut(dataLinesOut),
    .dataLinesOe(dataLinesOe)
);

// file: test/asac_mem_model.sv
`timescale 1ns/10ps
module asac_mem_model (
    input asac_pkg::asac_pins_type memPins,
    input wire logic [7:0] dataLinesOut,
    input wire logic dataLinesOe,
    output logic [7:0] dataLinesIn
);
    logic [7:0] mem [asac_pkg::MEM_WORDS];
    logic [7:0] rdData;
    logic drive;
    // drive only when selected, gated and not writing; data lags the address
    assign drive = !memPins.selectN && !memPins.gateN && memPins.strobeN;
    assign #35 rdData = mem[memPins.addressLines];
    // wire level: controller, device, else a wrong pattern
    assign dataLinesIn = dataLinesOe ? dataLinesOut : (drive ? rdData : ~rdData);
    // store at the first rise of select or strobe
    always @(posedge (memPins.selectN | memPins.strobeN))
        mem[memPins.addressLines] <= dataLinesIn;
endmodule

// file: test/async_sram_access_control_tb.sv
`timescale 1ns/10ps
module async_sram_access_control_tb;
    logic clk_sys = 1'h0;
    logic nrst = 1'h0;
    logic reqValid = 1'h0;
    logic reqReady, rspValid, dataLinesOe;
    asac_pkg::asac_req_type reqData = '0;
    logic [7:0] rspData, dataLinesIn, dataLinesOut;
    asac_pkg::asac_pins_type memPins;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    always #12.5 clk_sys = ~clk_sys;
    async_sram_access_control DUT (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .reqValid(reqValid),
        .reqReady(reqReady),
        .reqData(reqData),
        .rspValid(rspValid),
        .rspData(rspData),
        .memPins(memPins),
        .dataLinesIn(dataLinesIn),
        .dataLinesOut(dataLinesOut),
        .dataLinesOe(dataLinesOe)
    );
    asac_mem_model MEM (
        .memPins(memPins),
        .dataLinesOut(dataLinesOut),
        .dataLinesOe(dataLinesOe),
        .dataLinesIn(dataLinesIn)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one request, held until taken; a read waits for its data
    task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d, input logic hold);
        int n;
        n = 0;
        reqData <= '{write: wr, addr: a, wdata: d};
        reqValid <= 1'h1;
        do @(posedge clk_sys); while (reqReady !== 1'h1);
        if (!hold)
            reqValid <= 1'h0;
        if (!wr)
        begin
            do
            begin
                @(posedge clk_sys);
                n++;
            end
            while (rspValid !== 1'h1 && n < 9);
            check(n, 2 + asac_pkg::ACCESS_CYC);
            check(rspData, d);
        end
        else if (!hold)
            @(posedge clk_sys);
    endtask
    // idle pins while reset is held
    task automatic reset_state;
        check(memPins, asac_pkg::PINS_IDLE);
        check({dataLinesOe, rspValid, reqReady}, 3'h1);
    endtask
    // lowest and highest word, writes back to back
    task automatic edge_words;
        access(1'h1, 15'h0000, 8'h5A, 1'h1);
        access(1'h1, 15'h7FFF, 8'hA5, 1'h0);
        access(1'h0, 15'h0000, 8'h5A, 1'h0);
        access(1'h0, 15'h7FFF, 8'hA5, 1'h0);
    endtask
    // read held while busy is refused, then taken; overwrite
    task automatic overwrite;
        access(1'h1, 15'h1234, 8'h3C, 1'h1);
        access(1'h0, 15'h1234, 8'h3C, 1'h1);
        access(1'h1, 15'h1234, 8'hC3, 1'h1);
        access(1'h0, 15'h1234, 8'hC3, 1'h0);
    endtask
    // reset pulled in mid read: pins idle at once, read dropped, next read works
    task automatic midrun_reset;
        access(1'h1, 15'h0F0F, 8'h96, 1'h0);
        reqData <= '{write: 1'h0, addr: 15'h0F0F, wdata: 8'h00};
        reqValid <= 1'h1;
        do @(posedge clk_sys); while (reqReady !== 1'h1);
        reqValid <= 1'h0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'h0;
        @(posedge clk_sys);
        check(memPins, asac_pkg::PINS_IDLE);
        check({dataLinesOe, rspValid, reqReady}, 3'h1);
        nrst <= 1'h1;
        access(1'h0, 15'h0F0F, 8'h96, 1'h0);
    endtask
    // cut a hang short
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            conclude();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk_sys);
        reset_state();
        nrst <= 1'h1;
        edge_words();
        overwrite();
        midrun_reset();
        conclude();
    end
endmodule
